// ===== ecc_channel_ctrl.sv
// Per-channel control-source merge, idle detection, signalling capture and monitor pins
`timescale 1ns/1ps

module ecc_channel_ctrl #(
  parameter int unsigned IDLE_TIME_DIV = 1
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                frame_sync,
  input  wire logic                slot_tick,
  input  wire ecc_pkg::ecc_pins_t  serial_pins,
  input  wire logic [2:0]          link_bits,
  input  wire logic                link_dis_bit,
  input  wire ecc_pkg::ecc_sig_t   sig_in,
  input  wire logic [7:0]          pcm_rx_byte,
  input  wire logic [7:0]          pcm_tx_byte,
  input  wire logic [15:0]         status_flags,
  input  wire logic                receive_input_test_stream,
  input  wire logic                send_input_test_stream,
  output ecc_pkg::ecc_cmd_t        channel_cmd,
  output logic [4:0]               cmd_channel,
  output logic                     cmd_valid,
  output logic                     monitor_output_a,
  output logic                     monitor_output_b
);
  import ecc_pkg::*;

  logic [5:0]  signalling_slot_config;
  logic [5:0]  idle_detect_config;
  logic [7:0]  idle_compare_mask;
  logic [7:0]  idle_reference_byte;
  logic [6:0]  control_link_config;
  logic [5:0]  serial_pin_ignore_mask;
  logic [5:0]  flexible_pin_actions;
  logic [5:0]  flexible_link_bit_actions;
  logic [7:0]  monitor_pin_select;
  logic [4:0]  test_channel_select;
  logic [4:0]  per_channel_control [NCH];
  logic [7:0]  last_byte [NCH];
  logic [IDLE_CW-1:0] idle_count [NCH];
  logic [NCH-1:0] sig_enabled;
  logic [NCH-1:0] idle_flag;

  // Two-stage synchronisers for the pins
  ecc_pins_t   pins_s1, pins_s2;
  logic        fs_s1, fs_s2, fs_d;
  always_ff @(posedge clock) begin
    pins_s1 <= serial_pins;
    pins_s2 <= pins_s1;
    fs_s1   <= frame_sync;
    fs_s2   <= fs_s1;
    fs_d    <= fs_s2;
  end

  logic [CHW-1:0] slot;
  always_ff @(posedge clock) begin
    if (sys_rst || (fs_s2 && !fs_d)) begin
      slot <= '0;
    end else if (slot_tick) begin
      slot <= slot + 5'h01;
    end
  end

  // APB slave: answer prepared in setup, completed in first access cycle
  logic [7:0] idx;
  logic       hit;
  logic [31:0] rd_val;
  logic       wr_en;
  assign idx   = paddr[9:2];
  assign wr_en = psel && penable && pready && pwrite;
  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    if (idx >= IDX_CH_FIRST && idx <= IDX_CH_LAST) begin
      rd_val = {27'h0, per_channel_control[idx[4:0]]};
    end else begin
      unique case (idx)
        IDX_SIG_CFG:  rd_val = {26'h0, signalling_slot_config};
        IDX_IDLE_CFG: rd_val = {26'h0, idle_detect_config};
        IDX_IDLE_MSK: rd_val = {24'h0, idle_compare_mask};
        IDX_IDLE_REF: rd_val = {24'h0, idle_reference_byte};
        IDX_SIG_STAT: rd_val = sig_enabled;
        IDX_IDLE_ST:  rd_val = idle_flag;
        IDX_LINK_CFG: rd_val = {25'h0, control_link_config};
        IDX_PIN_MASK: rd_val = {26'h0, serial_pin_ignore_mask};
        IDX_FLEX_PIN: rd_val = {26'h0, flexible_pin_actions};
        IDX_FLEX_LNK: rd_val = {26'h0, flexible_link_bit_actions};
        IDX_TEST_CH:  rd_val = {27'h0, test_channel_select};
        IDX_MON_SEL:  rd_val = {24'h0, monitor_pin_select};
        default:      hit = 1'b0;
      endcase
    end
    if (paddr[1:0] != 2'b00 || paddr[31:10] != '0) begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0 : rd_val;
      pslverr <= !hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      signalling_slot_config    <= RST_SIG_CFG;
      idle_detect_config        <= RST_IDLE_CFG;
      idle_compare_mask         <= RST_IDLE_MSK;
      idle_reference_byte       <= RST_IDLE_REF;
      control_link_config       <= RST_LINK_CFG;
      serial_pin_ignore_mask    <= RST_PIN_MASK;
      flexible_pin_actions      <= RST_FLEX;
      flexible_link_bit_actions <= RST_FLEX;
      monitor_pin_select        <= RST_MON_SEL;
      test_channel_select       <= RST_CH;
    end else if (wr_en && !pslverr) begin
      unique case (idx)
        IDX_SIG_CFG:  signalling_slot_config    <= pwdata[5:0];
        IDX_IDLE_CFG: idle_detect_config        <= pwdata[5:0];
        IDX_IDLE_MSK: idle_compare_mask         <= pwdata[7:0];
        IDX_IDLE_REF: idle_reference_byte       <= pwdata[7:0];
        IDX_LINK_CFG: control_link_config       <= pwdata[6:0];
        IDX_PIN_MASK: serial_pin_ignore_mask    <= pwdata[5:0];
        IDX_FLEX_PIN: flexible_pin_actions      <= pwdata[5:0];
        IDX_FLEX_LNK: flexible_link_bit_actions <= pwdata[5:0];
        IDX_TEST_CH:  test_channel_select       <= pwdata[4:0];
        IDX_MON_SEL:  monitor_pin_select        <= pwdata[7:0];
        default:      ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          per_channel_control[g] <= RST_CH;
        end else if (wr_en && !pslverr && idx == IDX_CH_FIRST + 8'(g)) begin
          per_channel_control[g] <= pwdata[4:0];
        end
      end
    end
  endgenerate

  logic [7:0] sig_byte;
  logic [1:0] fsel;
  logic       hi_bit, lo_bit;
  logic [4:0] hi_ch, lo_ch;
  assign sig_byte = signalling_slot_config[SG_SRC] ? sig_in.tx_byte : sig_in.rx_byte;
  assign fsel     = signalling_slot_config[SG_SEL+:2];
  assign hi_bit   = sig_byte[3'd4 + 3'(fsel)];
  assign lo_bit   = sig_byte[3'(fsel)];
  assign hi_ch    = {1'b0, sig_in.frame_no};
  assign lo_ch    = {1'b1, sig_in.frame_no};
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sig_enabled <= '1;
    end else if (sig_in.valid && !signalling_slot_config[SG_HOLD]) begin
      sig_enabled[hi_ch] <= hi_bit ^ signalling_slot_config[SG_INV];
      sig_enabled[lo_ch] <= lo_bit ^ signalling_slot_config[SG_INV];
    end
  end

  logic [7:0]         idle_byte, idle_ref;
  logic               idle_match;
  logic [IDLE_CW-1:0] idle_limit;
  assign idle_byte  = idle_detect_config[ID_SRC] ? pcm_tx_byte : pcm_rx_byte;
  assign idle_ref   = idle_detect_config[ID_MODE] ? last_byte[slot] : idle_reference_byte;
  assign idle_match = ((idle_byte ^ idle_ref) & ~idle_compare_mask) == 8'h00;
  assign idle_limit = IDLE_CW'(IDLE_TIME_US[idle_detect_config[ID_TIME+:3]] / FRAME_US / IDLE_TIME_DIV);

  always_ff @(posedge clock) begin
    if (slot_tick) begin
      last_byte[slot] <= idle_byte;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      idle_flag <= '0;
      for (int i = 0; i < NCH; i++) begin
        idle_count[i] <= '0;
      end
    end else if (slot_tick) begin
      if (!idle_match || !idle_detect_config[ID_ON]) begin
        idle_count[slot] <= '0;
        idle_flag[slot]  <= 1'b0;
      end else if (idle_count[slot] < idle_limit) begin
        idle_count[slot] <= idle_count[slot] + 20'h00001;
      end else begin
        idle_flag[slot] <= 1'b1;
      end
    end
  end

  logic flex_bit;
  always_comb begin
    unique case (control_link_config[LK_SEL+:2])
      2'b11:   flex_bit = link_bits[2];
      2'b10:   flex_bit = link_bits[1];
      2'b01:   flex_bit = link_bits[0];
      default: flex_bit = 1'b0;
    endcase
  end

  // Merge of all sources for the channel in the current slot
  ecc_pins_t pin_on;
  logic [5:0] fp_act, fl_act;
  logic [4:0] cc;
  logic       hw_byp, hw_nlp, hw_frz, hw_cnv, hw_hrs, hw_mrs;
  ecc_cmd_t   next_cmd;
  assign cc     = per_channel_control[slot];
  assign pin_on = pins_s2 & ~serial_pin_ignore_mask;
  // flexible pin actions gated by its ignore bit
  assign fp_act = pin_on.flexible_control ? flexible_pin_actions : 6'h00;
  assign fl_act = flex_bit ? flexible_link_bit_actions : 6'h00;
  assign hw_byp = pin_on.bypass || fp_act[AC_BYP] || fl_act[AC_BYP]
                  || (!pins_s2.canceller_enable && !serial_pin_ignore_mask[PM_ENC])
                  || (control_link_config[LK_DISHW] && link_dis_bit)
                  || (signalling_slot_config[SG_ON] && !sig_enabled[slot])
                  || idle_flag[slot];
  assign hw_nlp = pin_on.nonlinear_processor_off || fp_act[AC_NLP] || fl_act[AC_NLP];
  assign hw_frz = pin_on.coef_freeze || fp_act[AC_FRZ] || fl_act[AC_FRZ];
  assign hw_cnv = pin_on.law_conversion_off || fp_act[AC_CNV] || fl_act[AC_CNV];
  assign hw_hrs = fp_act[AC_HRS] || fl_act[AC_HRS];
  assign hw_mrs = fp_act[AC_MRS] || fl_act[AC_MRS];

  always_comb begin
    if (cc[CH_ESC]) begin
      next_cmd.bypass                  = cc[CH_BYP];
      next_cmd.nonlinear_processor_off = cc[CH_NLP];
      next_cmd.coef_freeze             = cc[CH_FRZ];
      next_cmd.law_conversion_off      = cc[CH_CNV];
      next_cmd.coef_reset              = cc[CH_BYP];
      next_cmd.meter_reset             = cc[CH_BYP];
    end else begin
      next_cmd.bypass                  = cc[CH_BYP] || hw_byp;
      next_cmd.nonlinear_processor_off = cc[CH_NLP] || hw_nlp;
      next_cmd.coef_freeze             = cc[CH_FRZ] || hw_frz;
      next_cmd.law_conversion_off      = cc[CH_CNV] || hw_cnv;
      next_cmd.coef_reset              = cc[CH_BYP] || hw_byp || hw_hrs;
      next_cmd.meter_reset             = cc[CH_BYP] || hw_byp || hw_mrs;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      channel_cmd <= '0;
      cmd_channel <= '0;
      cmd_valid   <= 1'b0;
    end else begin
      cmd_valid <= slot_tick;
      if (slot_tick) begin
        channel_cmd <= next_cmd;
        cmd_channel <= slot;
      end
    end
  end

  function automatic logic mon_pick(input logic [3:0] code, input logic first);
    logic test_ch;
    test_ch = (slot == test_channel_select);
    unique case (code)
      MON_IDLE: mon_pick = idle_flag[slot];
      MON_P2:   mon_pick = first && status_flags[MON_P2];
      MON_RXT:  mon_pick = test_ch && receive_input_test_stream;
      MON_TXT:  mon_pick = test_ch && send_input_test_stream;
      default:  mon_pick = status_flags[code];
    endcase
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      monitor_output_a <= 1'b0;
      monitor_output_b <= 1'b0;
    end else begin
      monitor_output_a <= mon_pick(monitor_pin_select[7:4], 1'b1);
      monitor_output_b <= mon_pick(monitor_pin_select[3:0], 1'b0);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_sw_only;
    slot_tick && cc[CH_ESC] |=> channel_cmd.bypass == $past(cc[CH_BYP]);
  endproperty
  a_sw_only: assert property (p_sw_only) else $error("exclusive bypass mismatch");

  property p_or_merge;
    slot_tick && !cc[CH_ESC] && cc[CH_FRZ] |=> channel_cmd.coef_freeze;
  endproperty
  a_or_merge: assert property (p_or_merge) else $error("register freeze lost");

  property p_pin_masked;
    slot_tick && cc == 5'h00 && serial_pin_ignore_mask[PM_FRZ] && flex_bit == 1'b0
      && pin_on.flexible_control == 1'b0 |=> !channel_cmd.coef_freeze;
  endproperty
  a_pin_masked: assert property (p_pin_masked) else $error("masked pin honoured");

  property p_flex_conv;
    slot_tick && !cc[CH_ESC] && pin_on.flexible_control && flexible_pin_actions[AC_CNV]
      |=> channel_cmd.law_conversion_off;
  endproperty
  a_flex_conv: assert property (p_flex_conv) else $error("flex conversion off missing");

  property p_byp_reset;
    cmd_valid && channel_cmd.bypass |-> channel_cmd.coef_reset && channel_cmd.meter_reset;
  endproperty
  a_byp_reset: assert property (p_byp_reset) else $error("bypass without reset");

  property p_idle_byp;
    slot_tick && idle_flag[slot] && !cc[CH_ESC] |=> channel_cmd.bypass;
  endproperty
  a_idle_byp: assert property (p_idle_byp) else $error("idle channel not bypassed");

  property p_idle_off;
    !idle_detect_config[ID_ON] && slot_tick |=> !idle_flag[$past(slot)];
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle flag while disabled");

  property p_hold;
    signalling_slot_config[SG_HOLD] |=> $stable(sig_enabled);
  endproperty
  a_hold: assert property (p_hold) else $error("flags updated while held");

  property p_mon_b_p2;
    monitor_pin_select[3:0] == MON_P2 |=> !monitor_output_b;
  endproperty
  a_mon_b_p2: assert property (p_mon_b_p2) else $error("second level on pin b");

  property p_apb_ans;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("apb answer timing");

  c_idle: cover property (slot_tick && idle_flag[slot]);
  c_flex: cover property (cmd_valid && channel_cmd.law_conversion_off && channel_cmd.bypass);
  c_sig:  cover property (sig_in.valid && $changed(sig_enabled));
endmodule

// ===== ecc_pkg.sv
// Constants, register map and carrier types for the echo channel control-source block
package ecc_pkg;
  localparam int NCH = 32;
  localparam int CHW = 5;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SIG_CFG  = 8'h31;
  localparam logic [7:0] IDX_IDLE_CFG = 8'h32;
  localparam logic [7:0] IDX_IDLE_MSK = 8'h33;
  localparam logic [7:0] IDX_IDLE_REF = 8'h34;
  localparam logic [7:0] IDX_SIG_STAT = 8'h35;
  localparam logic [7:0] IDX_IDLE_ST  = 8'h36;
  localparam logic [7:0] IDX_CH_FIRST = 8'h40;
  localparam logic [7:0] IDX_CH_LAST  = 8'h5F;
  localparam logic [7:0] IDX_LINK_CFG = 8'h60;
  localparam logic [7:0] IDX_PIN_MASK = 8'h6B;
  localparam logic [7:0] IDX_FLEX_PIN = 8'h6C;
  localparam logic [7:0] IDX_FLEX_LNK = 8'h6D;
  localparam logic [7:0] IDX_TEST_CH  = 8'h6E;
  localparam logic [7:0] IDX_MON_SEL  = 8'h6F;
  // Reset values
  localparam logic [5:0] RST_SIG_CFG  = 6'h12;
  localparam logic [5:0] RST_IDLE_CFG = 6'h1D;
  localparam logic [7:0] RST_IDLE_MSK = 8'h00;
  localparam logic [7:0] RST_IDLE_REF = 8'h55;
  localparam logic [6:0] RST_LINK_CFG = 7'h00;
  localparam logic [5:0] RST_PIN_MASK = 6'h3F;
  localparam logic [5:0] RST_FLEX     = 6'h00;
  localparam logic [7:0] RST_MON_SEL  = 8'hFE;
  localparam logic [4:0] RST_CH       = 5'h00;
  // Per-channel control word fields
  localparam int CH_ESC = 0;
  localparam int CH_BYP = 1;
  localparam int CH_NLP = 2;
  localparam int CH_FRZ = 3;
  localparam int CH_CNV = 4;
  // Action fields of both flexible action registers
  localparam int AC_CNV = 0;
  localparam int AC_HRS = 1;
  localparam int AC_MRS = 2;
  localparam int AC_FRZ = 3;
  localparam int AC_NLP = 4;
  localparam int AC_BYP = 5;
  // Serial pin ignore mask fields
  localparam int PM_FLX = 0;
  localparam int PM_ENC = 1;
  localparam int PM_CNV = 2;
  localparam int PM_FRZ = 3;
  localparam int PM_NLP = 4;
  localparam int PM_BYP = 5;
  // Signalling slot config fields
  localparam int SG_HOLD = 0;
  localparam int SG_SEL  = 1;
  localparam int SG_INV  = 3;
  localparam int SG_SRC  = 4;
  localparam int SG_ON   = 5;
  // Idle detect config fields
  localparam int ID_SRC  = 0;
  localparam int ID_MODE = 1;
  localparam int ID_TIME = 2;
  localparam int ID_ON   = 5;
  // Control link config fields
  localparam int LK_DISHW = 4;
  localparam int LK_SEL   = 2;
  // Monitor selector codes
  localparam logic [3:0] MON_IDLE = 4'h0;
  localparam logic [3:0] MON_P2   = 4'h2;
  localparam logic [3:0] MON_RXT  = 4'hC;
  localparam logic [3:0] MON_TXT  = 4'hD;
  localparam logic [3:0] MON_FAR  = 4'hE;
  localparam logic [3:0] MON_NEAR = 4'hF;
  // Idle protection times in microseconds, one frame lasts 125 us
  localparam int unsigned FRAME_US = 125;
  localparam int unsigned IDLE_TIME_US [8] = '{64000, 128000, 512000, 1000000,
                                              4100000, 8200000, 32800000, 65500000};
  localparam int IDLE_CW = 20;

  typedef struct packed {
    logic bypass;
    logic nonlinear_processor_off;
    logic coef_freeze;
    logic law_conversion_off;
    logic canceller_enable;
    logic flexible_control;
  } ecc_pins_t;

  typedef struct packed {
    logic law_conversion_off;
    logic coef_freeze;
    logic nonlinear_processor_off;
    logic bypass;
    logic coef_reset;
    logic meter_reset;
  } ecc_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] frame_no;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
  } ecc_sig_t;
endpackage

// ===== ecc_line_ctrl_model.sv
// Line controller model: slot timing, frame sync, serial pins and control link bits
`timescale 1ns/1ps
module ecc_line_ctrl_model (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire ecc_pkg::ecc_pins_t pins_req,
  input  wire logic [2:0]        link_req,
  output logic                   frame_sync,
  output logic                   slot_tick,
  output ecc_pkg::ecc_pins_t     serial_pins,
  output logic [2:0]             link_bits,
  output logic                   link_dis_bit
);
  import ecc_pkg::*;
  logic [6:0] cnt;
  always_ff @(posedge clock) begin
    if (sys_rst)
      cnt <= 7'h00;
    else
      cnt <= cnt + 7'h01;
  end
  // Four cycles per slot, 32 slots per frame
  always_ff @(posedge clock) begin
    slot_tick    <= !sys_rst && cnt[1:0] == 2'h3;
    frame_sync   <= !sys_rst && cnt[6:2] == 5'h00;
    link_dis_bit <= cnt[0];
  end
  // Pins move only at frame start, so a slot never sees a half-changed set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serial_pins <= '0;
      link_bits   <= 3'h0;
    end else if (cnt == 7'h7F) begin
      serial_pins <= pins_req;
      link_bits   <= link_req;
    end
  end
endmodule

// ===== tb_echo_channel_control_sources.sv
// Self-checking bench for the channel control-source block
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); \
    end \
  end
module tb_echo_channel_control_sources;
  import ecc_pkg::*;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, er_v;
  logic        frame_sync, slot_tick, link_dis_bit, cmd_valid, mon_a, mon_b, rx_ts, tx_ts;
  logic [31:0] paddr, pwdata, prdata, rd_v;
  ecc_pins_t   serial_pins, pins_req, p;
  ecc_cmd_t    channel_cmd;
  ecc_sig_t    sig_in;
  logic [2:0]  link_bits, link_req, lk;
  logic [7:0]  rx_b, tx_b;
  logic [15:0] status_flags;
  logic [4:0]  cmd_channel, cr, ch;
  logic [5:0]  m, fa, la;
  logic [1:0]  sel;
  int          err_count, checks_done, seed;
  logic [7:0]  ri [9] = '{IDX_SIG_CFG, IDX_IDLE_CFG, IDX_IDLE_MSK, IDX_IDLE_REF, IDX_LINK_CFG,
                          IDX_PIN_MASK, IDX_FLEX_PIN, IDX_FLEX_LNK, IDX_MON_SEL};
  logic [31:0] rv [9] = '{32'(RST_SIG_CFG), 32'(RST_IDLE_CFG), 32'(RST_IDLE_MSK), 32'(RST_IDLE_REF),
                          32'(RST_LINK_CFG), 32'(RST_PIN_MASK), 32'(RST_FLEX), 32'(RST_FLEX), 32'(RST_MON_SEL)};
  logic [31:0] rm [9] = '{32'h3F, 32'h3F, 32'hFF, 32'hFF, 32'h7F, 32'h3F, 32'h3F, 32'h3F, 32'hFF};

  ecc_channel_ctrl #(.IDLE_TIME_DIV(512)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sync(frame_sync), .slot_tick(slot_tick), .serial_pins(serial_pins), .link_bits(link_bits),
    .link_dis_bit(link_dis_bit), .sig_in(sig_in), .pcm_rx_byte(rx_b), .pcm_tx_byte(tx_b),
    .status_flags(status_flags), .receive_input_test_stream(rx_ts), .send_input_test_stream(tx_ts),
    .channel_cmd(channel_cmd), .cmd_channel(cmd_channel), .cmd_valid(cmd_valid),
    .monitor_output_a(mon_a), .monitor_output_b(mon_b));

  ecc_line_ctrl_model model_u (
    .clock(clock), .sys_rst(sys_rst), .pins_req(pins_req), .link_req(link_req), .frame_sync(frame_sync),
    .slot_tick(slot_tick), .serial_pins(serial_pins), .link_bits(link_bits), .link_dis_bit(link_dis_bit));

  always #10 clock = ~clock;
  // Busy receive data keeps the idle detector from matching on two visits in a row
  always @(posedge clock) begin
    rx_b  <= rx_b + 8'h25;
    tx_b  <= tx_b ^ 8'h5A;
    rx_ts <= ~rx_ts;
    tx_ts <= rx_b[0];
  end

  function automatic ecc_cmd_t exp_cmd(ecc_pins_t q, logic [5:0] k, logic [5:0] a, logic [5:0] l,
                                       logic [1:0] s, logic [2:0] b, logic [4:0] c);
    ecc_cmd_t e;
    logic     f, x, h;
    f = !k[PM_FLX] & q.flexible_control;
    x = s == 2'h3 ? b[2] : s == 2'h2 ? b[1] : s == 2'h1 ? b[0] : 1'b0;
    h = !c[CH_ESC];
    e.bypass = c[CH_BYP] | h & (!k[PM_BYP] & q.bypass | !k[PM_ENC] & !q.canceller_enable
               | f & a[AC_BYP] | x & l[AC_BYP]);
    e.law_conversion_off = c[CH_CNV] | h & (!k[PM_CNV] & q.law_conversion_off | f & a[AC_CNV] | x & l[AC_CNV]);
    e.coef_freeze = c[CH_FRZ] | h & (!k[PM_FRZ] & q.coef_freeze | f & a[AC_FRZ] | x & l[AC_FRZ]);
    e.nonlinear_processor_off = c[CH_NLP] | h & (!k[PM_NLP] & q.nonlinear_processor_off
                                | f & a[AC_NLP] | x & l[AC_NLP]);
    e.coef_reset = e.bypass | h & (f & a[AC_HRS] | x & l[AC_HRS]);
    e.meter_reset = e.bypass | h & (f & a[AC_MRS] | x & l[AC_MRS]);
    return e;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {22'h0, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_count++;
      summarize();
    end
  endtask

  task automatic wait_ch(input logic [4:0] c);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!(cmd_valid === 1'b1 && cmd_channel === c) && n < 400);
    if (n >= 400) begin
      err_count++;
      summarize();
    end
  endtask

  initial begin
    seed = 78;
    clock = 0;
    sys_rst = 1;
    {psel, penable, pwrite, paddr, pwdata, rx_b, tx_b, rx_ts, tx_ts} = '0;
    pins_req = '0;
    link_req = 3'h0;
    sig_in = '0;
    status_flags = 16'h0000;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      apb(0, ri[i], 0);
      `CHK(rd_v, rv[i])
      apb(1, ri[i], rv[i] ^ rm[i]);
      apb(0, ri[i], 0);
      `CHK(rd_v, rv[i] ^ rm[i])
      apb(1, ri[i], rv[i]);
    end
    apb(1, 8'h70, 32'hFF);
    apb(0, 8'h70, 0);
    `CHK({er_v, rd_v}, 33'h100000000)
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      {m, fa, la, cr, ch, sel} = 30'($random(seed));
      {p, lk} = 9'($random(seed));
      if (i == 0) begin
        p = '1;
        m = 6'h00;
        cr = 5'h03;
      end
      if (i == 1) begin
        la = 6'h21;
        sel = 2'h3;
        lk = 3'h4;
        cr = 5'h00;
      end
      pins_req <= p;
      link_req <= lk;
      apb(1, IDX_PIN_MASK, 32'(m));
      apb(1, IDX_FLEX_PIN, 32'(fa));
      apb(1, IDX_FLEX_LNK, 32'(la));
      apb(1, IDX_LINK_CFG, {28'h0, sel, 2'b00});
      apb(1, IDX_CH_FIRST + 8'(ch), 32'(cr));
      repeat (3) wait_ch(ch);
      `CHK(channel_cmd, exp_cmd(p, m, fa, la, sel, lk, cr))
    end
    $display("test control merge done");
    for (int c = 1; c < 16; c++) begin
      if (c == 12 || c == 13)
        continue;
      status_flags <= 16'($random(seed));
      apb(1, IDX_MON_SEL, 32'(c * 17));
      repeat (4) @(posedge clock);
      `CHK(mon_a, status_flags[c])
      `CHK(mon_b, (c == 2) ? 1'b0 : status_flags[c])
    end
    apb(1, IDX_TEST_CH, 32'h5);
    apb(1, IDX_MON_SEL, 32'hCD);
    wait_ch(5'd20);
    `CHK({mon_a, mon_b}, 2'b00)
    $display("test monitor done");
    // Only signalling may act: pins masked, link bit off, channel 3 register bits clear
    apb(1, IDX_PIN_MASK, 32'h3F);
    apb(1, IDX_LINK_CFG, 32'h00);
    apb(1, IDX_CH_FIRST + 8'd3, 32'h00);
    // Evaluation on, receive source, pair 5/1; send byte holds the opposite pair
    apb(1, IDX_SIG_CFG, 32'h22);
    sig_in <= {1'b1, 4'h3, 8'h02, 8'h20};
    @(posedge clock);
    sig_in.valid <= 1'b0;
    apb(0, IDX_SIG_STAT, 0);
    `CHK(rd_v, 32'hFFFFFFF7)
    repeat (2) wait_ch(5'd3);
    `CHK(channel_cmd, 6'b000111)
    apb(1, IDX_SIG_CFG, 32'h23);
    sig_in <= {1'b1, 4'h3, 8'h22, 8'h00};
    @(posedge clock);
    sig_in.valid <= 1'b0;
    apb(0, IDX_SIG_STAT, 0);
    `CHK(rd_v, 32'hFFFFFFF7)
    // Full mask makes every visit match; shortest interval is one frame here
    apb(1, IDX_IDLE_MSK, 32'hFF);
    apb(1, IDX_IDLE_CFG, 32'h20);
    repeat (3) wait_ch(5'd0);
    apb(0, IDX_IDLE_ST, 0);
    `CHK(rd_v, 32'hFFFFFFFF)
    apb(1, IDX_MON_SEL, 32'h00);
    repeat (4) @(posedge clock);
    `CHK({mon_a, mon_b}, 2'b11)
    // Busy receive data never meets the pattern on two visits in a row
    apb(1, IDX_IDLE_MSK, 32'h00);
    repeat (3) wait_ch(5'd0);
    apb(0, IDX_IDLE_ST, 0);
    `CHK(rd_v, 32'h00000000)
    $display("test signalling and idle done");
    summarize();
  end
endmodule
